/* File: src/fmlr_top.v */
// serial flash command block: wrap read (four-wire mode only), four-wire mode, locks, software reset
`include "fmlr_consts.vh"

module fmlr_top (
  input  wire        clk_in,
  input  wire        reset_n_in,
  input  wire        cs_n_in,
  input  wire        sclk_in,
  input  wire [3:0]  io_in,
  output wire [3:0]  io_out,
  output wire [3:0]  io_oe_out,
  input  wire        quad_enable_bit_in,
  input  wire        protection_scheme_select_in,
  input  wire        bp_region_protect_in,
  input  wire [23:0] query_addr_in,
  output wire        query_protect_out,
  input  wire [7:0]  mem_data_in,
  output wire [23:0] mem_addr_out,
  output wire        four_wire_opcode_mode_out,
  output wire        write_enable_latch_out,
  output wire [7:0]  read_parameter_bits_out,
  output wire        busy_out,
  output wire        sw_reset_out
);

  localparam ST_CMD   = 4'b0001;
  localparam ST_DUMMY = 4'b0010;
  localparam ST_OUT   = 4'b0100;
  localparam ST_IGN   = 4'b1000;

  // next address inside the wrap window
  function [23:0] wrap_next;
    input [23:0] a;
    input [1:0]  code;
    reg   [5:0]  mask;
    reg   [5:0]  low;
    begin
      mask = 6'h07;
      case (code)
        2'b00: mask = 6'h07;
        2'b01: mask = 6'h0f;
        2'b10: mask = 6'h1f;
        default: mask = 6'h3f;
      endcase
      low = a[5:0] + 6'h01;
      wrap_next = {a[23:6], (a[5:0] & ~mask) | (low & mask)};
    end
  endfunction

  // dummy clocks from the parameter code
  function [3:0] dummy_count;
    input [1:0] code;
    begin
      dummy_count = {1'b0, code, 1'b0} + 4'h2;
    end
  endfunction

  // reset release
  reg rst_s1_r;
  reg rst_s2_r;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  wire rst_n = rst_s2_r;

  // pin synchronisation
  wire [5:0] pin_s;

  fmlr_sync #(
    .W (6)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .d_in     ({cs_n_in, sclk_in, io_in}),
    .q_out    (pin_s)
  );

  wire       cs_s   = pin_s[5];
  wire       sclk_s = pin_s[4];
  wire [3:0] io_s   = pin_s[3:0];

  reg        sclk_d_r;
  reg        cs_d_r;
  reg [3:0]  st_r;
  reg [31:0] shift_r;
  reg [6:0]  cnt_r;
  reg [7:0]  op_r;
  reg [3:0]  dcnt_r;
  reg [7:0]  out_r;
  reg [3:0]  ob_r;
  reg [23:0] addr_r;
  reg [3:0]  io_out_r;
  reg [3:0]  io_oe_r;
  reg        qpi_r;
  reg        wel_r;
  reg [7:0]  rp_r;
  reg        armed_r;
  reg [10:0] busy_cnt_r;
  reg        busy_r;
  reg        sw_reset_r;
  reg        qprot_r;

  wire rise   = sclk_s & ~sclk_d_r;
  wire fall   = ~sclk_s & sclk_d_r;
  wire cs_end = cs_s & ~cs_d_r;
  wire cs_act = ~cs_s;

  // four bits per clock in four-wire mode, one on io_s[0] otherwise
  wire [31:0] sh_nxt  = qpi_r ? {shift_r[27:0], io_s}
                              : {shift_r[30:0], io_s[0]};
  wire [6:0]  step_in = qpi_r ? 7'd4 : 7'd1;
  wire [6:0]  cnt_nxt = (cnt_r >= `FMLR_LEN_SAT) ? cnt_r : cnt_r + step_in;

  // execution at the end of a frame
  wire exec   = cs_end & ~busy_r & (st_r != ST_IGN);
  wire ex_opc = exec & (cnt_r == `FMLR_LEN_OPC);
  wire ex_adr = exec & (cnt_r == `FMLR_LEN_ADDR);
  wire soft_rst = ex_opc & (op_r == `FMLR_OP_RST) & armed_r;

  wire lk_set_all = soft_rst
                  | (ex_opc & (op_r == `FMLR_OP_GLOCK) & wel_r);
  wire lk_clr_all = ex_opc & (op_r == `FMLR_OP_GUNLOCK) & wel_r;
  wire lk_wr      = ex_adr & wel_r
                  & ((op_r == `FMLR_OP_LOCK) | (op_r == `FMLR_OP_UNLOCK));
  wire lk_val     = (op_r == `FMLR_OP_LOCK);
  wire lk_rd_bit;
  wire lk_q_bit;

  fmlr_lock_bank u_lock (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n),
    .set_all_in (lk_set_all),
    .clr_all_in (lk_clr_all),
    .wr_en_in   (lk_wr),
    .wr_val_in  (lk_val),
    .wr_idx_in  (shift_r[`FMLR_LK_IDX_MSB:`FMLR_LK_IDX_LSB]),
    .rd_idx_in  (addr_r[`FMLR_LK_IDX_MSB:`FMLR_LK_IDX_LSB]),
    .rd_bit_out (lk_rd_bit),
    .q_idx_in   (query_addr_in[`FMLR_LK_IDX_MSB:`FMLR_LK_IDX_LSB]),
    .q_bit_out  (lk_q_bit)
  );

  // output byte source and stepping
  wire [7:0] src_byte = (op_r == `FMLR_OP_RDLOCK) ? {7'h00, lk_rd_bit}
                                                  : mem_data_in;
  wire [3:0] step_out = qpi_r ? 4'h4 : 4'h1;
  wire [3:0] ob_nxt   = ob_r + step_out;
  wire [1:0] wrap_cd  = rp_r[`FMLR_RP_WRAP_LSB+1:`FMLR_RP_WRAP_LSB];
  wire [1:0] dmy_cd   = rp_r[`FMLR_RP_DMY_LSB+1:`FMLR_RP_DMY_LSB];
  wire [31:0] rst_cyc = `FMLR_RST_CYC;

  // frame engine
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_r <= 1'b1;
      cs_d_r   <= 1'b1;
      st_r     <= ST_CMD;
      shift_r  <= 32'h0000_0000;
      cnt_r    <= 7'h00;
      op_r     <= 8'h00;
      dcnt_r   <= 4'h0;
      out_r    <= 8'h00;
      ob_r     <= 4'h0;
      addr_r   <= 24'h00_0000;
      io_out_r <= 4'h0;
      io_oe_r  <= 4'h0;
    end else begin
      sclk_d_r <= sclk_s;
      cs_d_r   <= cs_s;
      if (cs_end) begin
        st_r    <= ST_CMD;
        cnt_r   <= 7'h00;
        ob_r    <= 4'h0;
        io_oe_r <= 4'h0;
      end else if (cs_act && rise) begin
        case (st_r)
          ST_CMD: begin
            shift_r <= sh_nxt;
            cnt_r   <= cnt_nxt;
            if (busy_r) begin
              st_r <= ST_IGN;
            end
            if (cnt_nxt == `FMLR_LEN_OPC) begin
              op_r <= sh_nxt[7:0];
            end
            if (!busy_r && cnt_nxt == `FMLR_LEN_ADDR) begin
              if (op_r == `FMLR_OP_RDLOCK) begin
                addr_r <= sh_nxt[23:0];
                st_r   <= ST_OUT;
              end else if (op_r == `FMLR_OP_WRAP && qpi_r) begin
                addr_r <= sh_nxt[23:0];
                dcnt_r <= 4'h0;
                st_r   <= ST_DUMMY;
              end
            end
          end
          ST_DUMMY: begin
            dcnt_r <= dcnt_r + 4'h1;
            if (dcnt_r == dummy_count(dmy_cd) - 4'h1) begin
              st_r <= ST_OUT;
            end
          end
          ST_OUT: begin
            st_r <= ST_OUT;
          end
          ST_IGN: begin
            st_r <= ST_IGN;
          end
          default: begin
            st_r <= ST_IGN;
          end
        endcase
      end else if (cs_act && fall && st_r == ST_OUT) begin
        io_oe_r <= qpi_r ? 4'hf : 4'h2;
        if (ob_r == 4'h0) begin
          if (qpi_r) begin
            io_out_r <= src_byte[7:4];
            out_r    <= {src_byte[3:0], 4'h0};
          end else begin
            io_out_r <= {2'b00, src_byte[7], 1'b0};
            out_r    <= {src_byte[6:0], 1'b0};
          end
          ob_r <= step_out;
          if (op_r == `FMLR_OP_WRAP) begin
            addr_r <= wrap_next(addr_r, wrap_cd);
          end
        end else begin
          if (qpi_r) begin
            io_out_r <= out_r[7:4];
            out_r    <= {out_r[3:0], 4'h0};
          end else begin
            io_out_r <= {2'b00, out_r[7], 1'b0};
            out_r    <= {out_r[6:0], 1'b0};
          end
          ob_r <= (ob_nxt == 4'h8) ? 4'h0 : ob_nxt;
        end
      end
    end
  end

  // mode, latch, parameters and reset sequencing
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      qpi_r      <= 1'b0;
      wel_r      <= 1'b0;
      rp_r       <= `FMLR_RP_RESET;
      armed_r    <= 1'b0;
      busy_cnt_r <= 11'h000;
      busy_r     <= 1'b0;
      sw_reset_r <= 1'b0;
      qprot_r    <= 1'b1;
    end else begin
      sw_reset_r <= soft_rst;
      qprot_r    <= protection_scheme_select_in ? lk_q_bit
                                                : bp_region_protect_in;
      if (soft_rst) begin
        busy_cnt_r <= rst_cyc[10:0];
        busy_r     <= 1'b1;
      end else if (busy_cnt_r != 11'h000) begin
        busy_cnt_r <= busy_cnt_r - 11'h001;
        busy_r     <= (busy_cnt_r != 11'h001);
      end
      if (soft_rst) begin
        qpi_r   <= 1'b0;
        wel_r   <= 1'b0;
        rp_r    <= `FMLR_RP_RESET;
        armed_r <= 1'b0;
      end else if (exec && cnt_r >= `FMLR_LEN_OPC) begin
        armed_r <= ex_opc & (op_r == `FMLR_OP_RSTEN);
        if (ex_opc) begin
          case (op_r)
            `FMLR_OP_WREN: begin
              wel_r <= 1'b1;
            end
            `FMLR_OP_WRDI: begin
              wel_r <= 1'b0;
            end
            `FMLR_OP_ENTER4W: begin
              if (!qpi_r && quad_enable_bit_in) begin
                qpi_r <= 1'b1;
              end
            end
            `FMLR_OP_EXIT4W: begin
              if (qpi_r) begin
                qpi_r <= 1'b0;
              end
            end
            default: begin
              qpi_r <= qpi_r;
            end
          endcase
        end
        if (qpi_r && cnt_r == `FMLR_LEN_PARM && op_r == `FMLR_OP_SETPARM) begin
          rp_r <= shift_r[7:0];
        end
      end
    end
  end

  assign io_out                    = io_out_r;
  assign io_oe_out                 = io_oe_r;
  assign query_protect_out         = qprot_r;
  assign mem_addr_out              = addr_r;
  assign four_wire_opcode_mode_out = qpi_r;
  assign write_enable_latch_out    = wel_r;
  assign read_parameter_bits_out   = rp_r;
  assign busy_out                  = busy_r;
  assign sw_reset_out              = sw_reset_r;

endmodule // fmlr_top

/* File: src/fmlr_consts.vh */
// constants for the flash mode, lock and reset command block
`ifndef FMLR_CONSTS_VH
`define FMLR_CONSTS_VH

// opcodes
`define FMLR_OP_WREN     8'h06
`define FMLR_OP_WRDI     8'h04
`define FMLR_OP_WRAP     8'h0c
`define FMLR_OP_SETPARM  8'hc0
`define FMLR_OP_ENTER4W  8'h38
`define FMLR_OP_EXIT4W   8'hff
`define FMLR_OP_LOCK     8'h36
`define FMLR_OP_UNLOCK   8'h39
`define FMLR_OP_RDLOCK   8'h3d
`define FMLR_OP_GLOCK    8'h7e
`define FMLR_OP_GUNLOCK  8'h98
`define FMLR_OP_RSTEN    8'h66
`define FMLR_OP_RST      8'h99

// frame lengths in received bits
`define FMLR_LEN_OPC     7'd8
`define FMLR_LEN_PARM    7'd16
`define FMLR_LEN_ADDR    7'd32
`define FMLR_LEN_SAT     7'd64

// read parameter layout and reset value
`define FMLR_RP_RESET    8'h00
`define FMLR_RP_WRAP_LSB 0
`define FMLR_RP_DMY_LSB  4

// lock index taken from the address
`define FMLR_LK_IDX_MSB  23
`define FMLR_LK_IDX_LSB  16
`define FMLR_LK_COUNT    256

// reset recovery time
`define FMLR_T_RST_US    30
`define FMLR_CLK_MHZ     50
`define FMLR_RST_CYC     (`FMLR_T_RST_US * `FMLR_CLK_MHZ)

`endif

/* File: src/fmlr_sync.v */
// two flip-flop synchroniser for pin inputs
module fmlr_sync #(
  parameter W = 6
) (
  input  wire         clk_in,
  input  wire         rst_n_in,
  input  wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= {W{1'b1}};
      sync_r <= {W{1'b1}};
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;

endmodule // fmlr_sync

/* File: src/fmlr_lock_bank.v */
// volatile block/sector lock bits
`include "fmlr_consts.vh"

module fmlr_lock_bank (
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire       set_all_in,
  input  wire       clr_all_in,
  input  wire       wr_en_in,
  input  wire       wr_val_in,
  input  wire [7:0] wr_idx_in,
  input  wire [7:0] rd_idx_in,
  output wire       rd_bit_out,
  input  wire [7:0] q_idx_in,
  output wire       q_bit_out
);

  reg [`FMLR_LK_COUNT-1:0] lock_r;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_r <= {`FMLR_LK_COUNT{1'b1}};
    end else if (set_all_in) begin
      lock_r <= {`FMLR_LK_COUNT{1'b1}};
    end else if (clr_all_in) begin
      lock_r <= {`FMLR_LK_COUNT{1'b0}};
    end else if (wr_en_in) begin
      lock_r[wr_idx_in] <= wr_val_in;
    end
  end

  assign rd_bit_out = lock_r[rd_idx_in];
  assign q_bit_out  = lock_r[q_idx_in];

endmodule // fmlr_lock_bank

/* File: verif/fmlr_top_properties.sv */
// concurrent checks on the flash command block ports
module fmlr_top_properties (
  input wire       clk_in,
  input wire       reset_n_in,
  input wire       cs_n_in,
  input wire       quad_enable_bit_in,
  input wire       protection_scheme_select_in,
  input wire       bp_region_protect_in,
  input wire       query_protect_out,
  input wire [3:0] io_oe_out,
  input wire       four_wire_opcode_mode_out,
  input wire       write_enable_latch_out,
  input wire [7:0] read_parameter_bits_out,
  input wire       busy_out,
  input wire       sw_reset_out
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [3:0]  live_r;
  reg [11:0] busy_cnt_r;
  // live_r masks the two-flop reset release inside the block
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      live_r     <= 4'h0;
      busy_cnt_r <= 12'h000;
    end else begin
      live_r     <= {live_r[2:0], 1'b1};
      busy_cnt_r <= busy_out ? busy_cnt_r + 12'h001 : 12'h000;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!live_r[3]);
  property p_busy_follows; sw_reset_out |=> busy_out[*8]; endproperty
  a_busy_follows: assert property (p_busy_follows)
    else $error("busy missing after software reset");
  property p_busy_bound; busy_cnt_r <= 12'd1510; endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("busy held too long");
  property p_busy_len;
    $fell(busy_out) |-> $past(busy_cnt_r) >= 12'd1490;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy too short");
  property p_swr_clear;
    sw_reset_out |-> ##[0:2] (!write_enable_latch_out && read_parameter_bits_out == 8'h00);
  endproperty
  a_swr_clear: assert property (p_swr_clear)
    else $error("volatile state kept over software reset");
  property p_enter_qe;
    $rose(four_wire_opcode_mode_out) |-> $past(quad_enable_bit_in);
  endproperty
  a_enter_qe: assert property (p_enter_qe)
    else $error("mode entered with quad enable low");
  property p_mode_cs; $changed(four_wire_opcode_mode_out) |-> $past(cs_n_in, 2); endproperty
  a_mode_cs: assert property (p_mode_cs)
    else $error("mode changed inside a frame");
  property p_switch_keeps;
    $changed(four_wire_opcode_mode_out) && !sw_reset_out && !busy_out |->
      $stable(write_enable_latch_out) && $stable(read_parameter_bits_out);
  endproperty
  a_switch_keeps: assert property (p_switch_keeps)
    else $error("latch or parameters lost on mode switch");
  property p_oe_idle; cs_n_in[*6] |-> io_oe_out == 4'h0; endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("pins driven while deselected");
  property p_oe_mode;
    io_oe_out != 4'h0 |-> io_oe_out == (four_wire_opcode_mode_out ? 4'hf : 4'h2);
  endproperty
  a_oe_mode: assert property (p_oe_mode)
    else $error("wrong lines driven for mode");
  property p_query;
    !protection_scheme_select_in |=> query_protect_out == $past(bp_region_protect_in);
  endproperty
  a_query: assert property (p_query)
    else $error("protection ignores region decode");
  c_swr: cover property (sw_reset_out);
  c_enter: cover property ($rose(four_wire_opcode_mode_out));
  c_quad_out: cover property (io_oe_out == 4'hf);
  c_ser_out: cover property (io_oe_out == 4'h2);
endmodule // fmlr_top_properties

bind fmlr_top fmlr_top_properties chk_u (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n_in),
  .quad_enable_bit_in(quad_enable_bit_in),
  .protection_scheme_select_in(protection_scheme_select_in),
  .bp_region_protect_in(bp_region_protect_in), .query_protect_out(query_protect_out),
  .io_oe_out(io_oe_out), .four_wire_opcode_mode_out(four_wire_opcode_mode_out),
  .write_enable_latch_out(write_enable_latch_out),
  .read_parameter_bits_out(read_parameter_bits_out), .busy_out(busy_out),
  .sw_reset_out(sw_reset_out));

/* File: verif/fmlr_host_model.sv */
// host-side serial flash controller model driving the command link
module fmlr_host_model (
  output logic       cs_n_out,
  output logic       sclk_out,
  output logic [3:0] io_out,
  input  wire  [3:0] io_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    io_out   = 4'h0;
  end
  // one frame: bits out msb first on rising edges, then nrd units back
  task automatic xfer(input logic [63:0] tx, input int ntx, input int nrd, input bit q,
                      output logic [31:0] rx);
    int i;
    rx = '0;
    cs_n_out = 1'b0;
    for (i = ntx; i > 0; i = i - (q ? 4 : 1)) begin
      if (q) io_out = tx[i-1 -: 4];
      else io_out[0] = tx[i-1];
      #80 sclk_out = 1'b1;
      #80 sclk_out = 1'b0;
    end
    // device shifts on falling edges, sampled late in the cycle
    for (i = 0; i < nrd; i++) begin
      #80 sclk_out = 1'b1;
      #60 rx = q ? {rx[27:0], io_in} : {rx[30:0], io_in[1]};
      #20 sclk_out = 1'b0;
    end
    #80 cs_n_out = 1'b1;
    io_out = ~io_out;
    #160;
  endtask
endmodule // fmlr_host_model

/* File: verif/test_fmlr_top.sv */
// self-checking bench for the flash command block
module test_fmlr_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, reset_n_in, qe, pss, bpr;
  logic [23:0] qa;
  logic [31:0] rx;
  wire         cs_n, sclk, mode, write_enable_latch, busy, swr, qp;
  wire  [3:0]  hio, dio, doe, io_w;
  wire  [23:0] maddr;
  wire  [7:0]  parm;
  int          err_total, checks_done, swr_seen;
  assign io_w = (doe & dio) | (~doe & hio);
  fmlr_top dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n), .sclk_in(sclk),
    .io_in(io_w), .io_out(dio), .io_oe_out(doe), .quad_enable_bit_in(qe),
    .protection_scheme_select_in(pss), .bp_region_protect_in(bpr),
    .query_addr_in(qa), .query_protect_out(qp), .mem_data_in(maddr[7:0] ^ 8'h5a),
    .mem_addr_out(maddr), .four_wire_opcode_mode_out(mode), .write_enable_latch_out(write_enable_latch),
    .read_parameter_bits_out(parm), .busy_out(busy), .sw_reset_out(swr));
  fmlr_host_model host_u (.cs_n_out(cs_n), .sclk_out(sclk), .io_out(hio), .io_in(io_w));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (swr === 1'b1) swr_seen++;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmd(input logic [63:0] tx, input int n, input int nrd = 0, input bit q = 0);
    @(negedge clk_in);
    host_u.xfer(tx, n, nrd, q, rx);
  endtask
  task automatic rdlock(input logic [23:0] a);
    cmd({32'h0, 8'h3d, a}, 32, 8);
  endtask
  task automatic t_defaults;
    check("mode", 0, mode);
    check("parm", 0, parm);
    check("protect", 1, qp);
  endtask
  task automatic t_locks;
    cmd({8'h39, 24'h050000}, 32);
    rdlock(24'h050000);
    check("lock_nowel", 1, rx);
    cmd(8'h06, 8);
    cmd({8'h39, 24'h050000}, 32);
    rdlock(24'h050000);
    check("lock_clr", 0, rx);
    check("protect", 0, qp);
    qa = 24'h0a0505;
    repeat (2) @(negedge clk_in);
    check("protect_q", 1, qp);
    qa = 24'h050000;
    repeat (2) @(negedge clk_in);
    check("protect_back", 0, qp);
    pss = 1'b0;
    bpr = 1'b1;
    repeat (3) @(negedge clk_in);
    check("protect_bp", 1, qp);
    pss = 1'b1;
    bpr = 1'b0;
    cmd({8'h36, 24'h05ffff}, 32);
    rdlock(24'h050000);
    check("lock_set", 1, rx);
    cmd(8'h98, 8);
    rdlock(24'hab0000);
    check("glob_unl", 0, rx);
    cmd(8'h04, 8);
    cmd(8'h7e, 8);
    rdlock(24'hab0000);
    check("glob_nowel", 0, rx);
    cmd(8'h06, 8);
    cmd(8'h7e, 8);
    rdlock(24'hab0000);
    check("glob_lock", 1, rx);
  endtask
  task automatic t_modes;
    logic [23:0] a;
    qe = 1'b0;
    cmd(8'h38, 8);
    check("mode_noqe", 0, mode);
    qe = 1'b1;
    cmd(8'h38, 8);
    check("mode_on", 1, mode);
    check("wel_enter", 1, write_enable_latch);
    for (int c = 0; c < 4; c++) begin
      a = 24'h000100 + (24'h8 << c) - 24'h2;
      cmd({32'h0, 8'h0c, a} << (8 + 8 * c), 40 + 8 * c, 8, 1);
      check("wrap", {a[7:0] ^ 8'h5a, (a[7:0] + 8'h1) ^ 8'h5a, 16'h5a5b}, rx);
      if (c < 3) begin
        cmd({8'hc0, 2'b00, 2'(c + 1), 2'b00, 2'(c + 1)}, 16, 0, 1);
        check("parm", {2'b00, 2'(c + 1), 2'b00, 2'(c + 1)}, parm);
      end
    end
    cmd(8'hff, 8, 0, 1);
    check("mode_off", 0, mode);
    check("wel_exit", 1, write_enable_latch);
    check("parm_exit", 8'h33, parm);
  endtask
  task automatic t_swreset;
    check("busy_pre", 0, busy);
    cmd(8'h66, 8);
    cmd(8'h06, 8);
    cmd(8'h99, 8);
    check("swr_cancel", 0, swr_seen);
    cmd(8'h66, 8);
    cmd(8'h99, 8);
    check("swr", 1, swr_seen);
    check("busy", 1, busy);
    check("wel_rst", 0, write_enable_latch);
    check("parm_rst", 0, parm);
    cmd(8'h06, 8);
    check("wel_busy", 0, write_enable_latch);
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk_in);
    if (busy !== 1'b0) begin
      err_total++;
      tally_and_finish;
    end else begin
      rdlock(24'h050000);
      check("lock_rst", 1, rx);
      cmd(8'h06, 8);
      check("wel_after", 1, write_enable_latch);
    end
  endtask
  initial begin
    reset_n_in = 1'b0;
    qe = 1'b0;
    pss = 1'b1;
    bpr = 1'b0;
    qa = 24'h050000;
    repeat (10) @(negedge clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_defaults;
    t_locks;
    t_modes;
    t_swreset;
    tally_and_finish;
  end
endmodule // test_fmlr_top
